// ==== core/host_port_host.sv ====
// Host end: AHB-Lite controlled engine that runs accesses on the port pins
`timescale 1ns/10ps
`include "host_port_regs.svh"
module host_port_host
	import host_port_pkg::*;
#(
	parameter int RD_HOLD = `RD_CYC,
	parameter int WR_HOLD = `WR_CYC,
	parameter int IDLE_GAP = `IDLE_TXI,
	parameter int BOOT_WAIT = `POST_RESET_TXI
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	host_port_if.host bus
);

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	logic ap_wr;
	logic [7:0] ap_addr;
	logic [9:0] addr_reg;
	logic [31:0] wdata_reg;
	logic [31:0] rdata_reg;
	logic [2:0] config_reg;
	logic cmd_write;
	logic [3:0] cmd_lanes;
	logic done;
	host_state_t state;

	wire take = hsel & htrans[1] & hready;
	wire [7:0] a = haddr[7:0];
	wire busy = (state != ST_IDLE);
	wire wr_addr = ap_wr & (ap_addr == `REG_ADDR);
	wire wr_wdata = ap_wr & (ap_addr == `REG_WDATA);
	wire wr_cmd = ap_wr & (ap_addr == `REG_CMD);
	wire wr_status = ap_wr & (ap_addr == `REG_STATUS);
	wire wr_config = ap_wr & (ap_addr == `REG_CONFIG);
	// A start while busy is dropped
	wire go = wr_cmd & hwdata[`CMD_GO] & ~busy;
	wire [31:0] rd_mux;
	assign rd_mux = (a == `REG_ADDR) ? {22'h0, addr_reg} :
		(a == `REG_WDATA) ? wdata_reg :
		(a == `REG_CMD) ? {24'h0, cmd_lanes, 2'b00, cmd_write, 1'b0} :
		(a == `REG_STATUS) ? {30'h0, done, busy} :
		(a == `REG_RDATA) ? rdata_reg :
		(a == `REG_CONFIG) ? {29'h0, config_reg} : 32'h0000_0000;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ap_wr <= 1'b0;
			ap_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			ap_wr <= take & hwrite & (hsize == 3'h2);
			ap_addr <= a;
			if (take && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addr_reg <= 10'h000;
			wdata_reg <= 32'h0000_0000;
			config_reg <= `CONFIG_RST;
			cmd_write <= 1'b0;
			cmd_lanes <= 4'h0;
		end else begin
			if (wr_addr) addr_reg <= hwdata[9:0];
			if (wr_wdata) wdata_reg <= hwdata;
			if (wr_config && !busy) config_reg <= hwdata[2:0];
			if (wr_cmd && !busy) begin
				cmd_write <= hwdata[`CMD_WRITE];
				cmd_lanes <= hwdata[`CMD_LANE_LSB +: 4];
			end
		end
	end

	// ****************************************
	// Access engine
	// ****************************************
	logic [1:0] data_meta;
	logic [31:0] dmeta;
	logic [31:0] dsync;
	logic [4:0] cnt;
	logic sel_n;
	logic rd_strobe_n;
	logic [3:0] lanes_n;
	logic drive_wr;

	wire m16 = ~config_reg[`CFG_STRAP_HIGH] & config_reg[`CFG_STRAP_LOW];
	// Taken from the starting command: cmd_write only lands on that same edge
	wire [4:0] hold = hwdata[`CMD_WRITE] ? 5'(WR_HOLD) : 5'(RD_HOLD);
	wire last = (cnt == 5'd1);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dmeta <= 32'h0000_0000;
			dsync <= 32'h0000_0000;
		end else begin
			dmeta <= bus.data;
			dsync <= dmeta;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= ST_BOOT;
			cnt <= 5'(BOOT_WAIT);
			sel_n <= 1'b1;
			rd_strobe_n <= 1'b1;
			lanes_n <= 4'hF;
			drive_wr <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			done <= 1'b0;
		end else begin
			case (state)
				ST_BOOT: begin
					cnt <= cnt - 5'd1;
					if (last) state <= ST_IDLE;
				end
				ST_IDLE: begin
					if (go) begin
						state <= ST_STROBE;
						cnt <= hold;
						sel_n <= 1'b0;
						rd_strobe_n <= hwdata[`CMD_WRITE];
						lanes_n <= hwdata[`CMD_WRITE] ? ~hwdata[`CMD_LANE_LSB +: 4] : 4'hF;
						drive_wr <= hwdata[`CMD_WRITE];
					end
				end
				ST_STROBE: begin
					cnt <= cnt - 5'd1;
					if (last) begin
						state <= ST_GAP;
						cnt <= 5'(IDLE_GAP);
						sel_n <= 1'b1;
						rd_strobe_n <= 1'b1;
						lanes_n <= 4'hF;
						drive_wr <= 1'b0;
						if (!cmd_write) rdata_reg <= m16 ? {16'h0000, dsync[15:0]} : dsync;
					end
				end
				ST_GAP: begin
					cnt <= cnt - 5'd1;
					if (last) state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
			// A completion beats a simultaneous software clear
			if (state == ST_GAP && last) begin
				done <= 1'b1;
			end else if (wr_status && hwdata[`STAT_DONE]) begin
				done <= 1'b0;
			end
		end
	end

	// ****************************************
	// Pin mapping
	// ****************************************
	assign bus.cs_n = sel_n;
	assign bus.rd_n = rd_strobe_n;
	assign bus.addr = addr_reg[8:0];
	assign bus.width_strap_low = config_reg[`CFG_STRAP_LOW];
	assign bus.width_strap_high = config_reg[`CFG_STRAP_HIGH];
	assign bus.lane3_write_or_endian_pin = m16 ? config_reg[`CFG_ENDIAN] : lanes_n[3];
	assign bus.lane2_write_or_addr1_pin = m16 ? addr_reg[`ADDR_HALF_BIT] : lanes_n[2];
	assign bus.lane1_write_or_addr0_pin = lanes_n[1];
	assign bus.lane0_write_n = lanes_n[0];
	assign bus.host_dout = m16 ? {16'h0000, wdata_reg[15:0]} : wdata_reg;
	// Upper data half held at ground throughout 16-bit operation
	assign bus.host_oe = {drive_wr | m16, drive_wr};

endmodule : host_port_host

// ==== shared/host_port_regs.svh ====
// Constants shared by the host bus port ends and the host-side controller
// Function
// - 32-bit mode: upper width strap tied high
// - 16-bit mode: low strap high, upper low
// - Shared pin roles follow the width straps
// - 16-bit: lane-3 pin is static endian select
// - 16-bit: lane-2 pin is address bit A1
// - 16-bit: lane-1, lane-0 strobes write bytes
// - A2 to A10 select doubleword in all widths; the port serves only 32-bit and 16-bit
// - Data D0-D31 in 32-bit, D0-D15 in 16-bit
// - 16-bit host holds D16-D31 at ground
// - Paired halfword strobes write both lanes
// - One shared strobe writes the whole word
// - Joined low strobes write whole halfword
// - Host drives chip select and read strobe
// - Host strobes long enough for access time
// - Drive data only when select and read low
// - Write ends on select or strobe rising
// - 8-bit mode: both straps tied low
// - Host idles two core clocks between accesses
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// ****************************************
// Controller register map (byte offsets)
// ****************************************
`define REG_ADDR 8'h00
`define REG_WDATA 8'h04
`define REG_CMD 8'h08
`define REG_STATUS 8'h0C
`define REG_RDATA 8'h10
`define REG_CONFIG 8'h14

// ****************************************
// Field positions and reset values
// ****************************************
`define CMD_GO 0
`define CMD_WRITE 1
`define CMD_LANE_LSB 4
`define STAT_BUSY 0
`define STAT_DONE 1
`define CFG_STRAP_LOW 0
`define CFG_STRAP_HIGH 1
`define CFG_ENDIAN 2
`define CONFIG_RST 3'h2
`define ADDR_BITS 9
`define ADDR_HALF_BIT 9

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 50
`define RD_ACCESS_NS 130
`define WR_ACCESS_NS 90
`define IDLE_TXI 2
`define POST_RESET_TXI 20
`define NS_TO_CYC(ns) ((((ns) * `CLK_MHZ) + 999) / 1000)
`define RD_CYC `NS_TO_CYC(`RD_ACCESS_NS)
`define WR_CYC `NS_TO_CYC(`WR_ACCESS_NS)

`endif

// ==== shared/host_port_pkg.sv ====
// Types shared by the host bus port ends
package host_port_pkg;
	typedef enum logic [1:0] {WIDTH_8, WIDTH_16, WIDTH_32} bus_width_t;
	typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_STROBE, ST_GAP} host_state_t;
endpackage : host_port_pkg

// ==== shared/host_port_if.sv ====
// Pin-level carrier between the host bus controller and the device port
`timescale 1ns/10ps
interface host_port_if;
	logic cs_n;
	logic rd_n;
	logic lane3_write_or_endian_pin;
	logic lane2_write_or_addr1_pin;
	logic lane1_write_or_addr0_pin;
	logic lane0_write_n;
	logic [8:0] addr;
	logic width_strap_low;
	logic width_strap_high;
	logic [31:0] host_dout;
	logic [1:0] host_oe;
	logic [31:0] dev_dout;
	logic [1:0] dev_oe;
	logic [31:0] data;

	// Per-halfword resolution; an undriven half reads as pulled low
	assign data[15:0] = dev_oe[0] ? dev_dout[15:0] : (host_oe[0] ? host_dout[15:0] : 16'h0000);
	assign data[31:16] = dev_oe[1] ? dev_dout[31:16] :
		(host_oe[1] ? host_dout[31:16] : 16'h0000);

	modport device (
		input cs_n,
		input rd_n,
		input lane3_write_or_endian_pin,
		input lane2_write_or_addr1_pin,
		input lane1_write_or_addr0_pin,
		input lane0_write_n,
		input addr,
		input width_strap_low,
		input width_strap_high,
		input data,
		output dev_dout,
		output dev_oe
	);
	modport host (
		output cs_n,
		output rd_n,
		output lane3_write_or_endian_pin,
		output lane2_write_or_addr1_pin,
		output lane1_write_or_addr0_pin,
		output lane0_write_n,
		output addr,
		output width_strap_low,
		output width_strap_high,
		output host_dout,
		output host_oe,
		input data
	);
endinterface : host_port_if

// ==== core/host_port_device.sv ====
// Device end: asynchronous memory-style slave port onto a shared word memory
`timescale 1ns/10ps
`include "host_port_regs.svh"
module host_port_device
	import host_port_pkg::*;
#(
	parameter int DEPTH = 512
) (
	input wire logic ref_clk,
	input wire logic rst,
	host_port_if.device bus,
	input wire logic [8:0] user_addr,
	output logic [31:0] user_rdata,
	output logic write_done,
	output bus_width_t bus_width,
	output logic endian_select
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	localparam int SYNC_W = 49;

	logic [SYNC_W-1:0] pin_meta;
	logic [SYNC_W-1:0] pin_sync;
	wire [SYNC_W-1:0] pin_raw = {bus.cs_n, bus.rd_n, bus.lane3_write_or_endian_pin,
		bus.lane2_write_or_addr1_pin, bus.lane1_write_or_addr0_pin, bus.lane0_write_n,
		bus.width_strap_high, bus.width_strap_low, bus.addr, bus.data};

	// Strobes, straps, address and data all cross from the host's timing
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_meta <= '1;
			pin_sync <= '1;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	wire s_cs_n = pin_sync[48];
	wire s_rd_n = pin_sync[47];
	wire s_pin3 = pin_sync[46];
	wire s_pin2 = pin_sync[45];
	wire s_pin1 = pin_sync[44];
	wire s_pin0 = pin_sync[43];
	wire s_strap_high = pin_sync[42];
	wire s_strap_low = pin_sync[41];
	wire [8:0] s_addr = pin_sync[40:32];
	wire [31:0] s_data = pin_sync[31:0];

	// ****************************************
	// Width and pin-role decode
	// ****************************************
	wire is32 = s_strap_high;
	wire is16 = ~s_strap_high & s_strap_low;
	wire endian_now = is16 & s_pin3;
	wire addr1 = is16 & s_pin2;
	// Upper half of the word is picked when A1 disagrees with big-endian order
	wire half_hi = addr1 ^ endian_now;

	// 8-bit mode is not served: no lane write strobe counts as active there, and a read drives no data
	wire [3:0] lane_n = is32 ? {s_pin3, s_pin2, s_pin1, s_pin0} :
		(is16 ? {2'b11, s_pin1, s_pin0} : 4'hF);
	wire [3:0] lane_en32 = ~lane_n;
	wire [1:0] lane_en16 = ~lane_n[1:0];
	wire [3:0] be_now = is16 ? (half_hi ? {lane_en16, 2'b00} : {2'b00, lane_en16}) :
		lane_en32;
	wire [31:0] wdata_now = is16 ? {s_data[15:0], s_data[15:0]} : s_data;

	wire sel = ~s_cs_n;
	wire wr_act = sel & (lane_n != 4'hF);
	wire rd_act = sel & ~s_rd_n & ~wr_act;

	// ****************************************
	// Write collection and commit
	// ****************************************
	logic wr_prev;
	logic [3:0] acc_be;
	logic [31:0] acc_data;
	logic [8:0] acc_addr;

	wire [3:0] next_acc_be = wr_prev ? (acc_be | be_now) : be_now;
	// Commit on the first cycle the access is seen inactive
	wire commit = wr_prev & ~wr_act;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_prev <= 1'b0;
			acc_be <= 4'h0;
			acc_data <= 32'h0000_0000;
			acc_addr <= 9'h000;
		end else begin
			wr_prev <= wr_act;
			if (wr_act) begin
				acc_be <= next_acc_be;
				acc_data <= wdata_now;
				acc_addr <= s_addr;
			end
		end
	end

	// ****************************************
	// Byte-lane memories
	// ****************************************
	logic [31:0] port_word;
	logic [31:0] user_word;

	for (genvar lane = 0; lane < 4; lane++) begin : g_lane
		logic [7:0] lane_mem [DEPTH];
		logic [7:0] port_q;
		logic [7:0] user_q;

		always_ff @(posedge ref_clk) begin
			if (commit && acc_be[lane]) begin
				lane_mem[acc_addr] <= acc_data[8*lane +: 8];
			end
			port_q <= lane_mem[s_addr];
			user_q <= lane_mem[user_addr];
		end

		assign port_word[8*lane +: 8] = port_q;
		assign user_word[8*lane +: 8] = user_q;
	end

	// ****************************************
	// Read drive
	// ****************************************
	// Uninitialised memory reads back as whatever the array holds
	wire [31:0] next_dout = is16 ? {16'h0000, half_hi ? port_word[31:16] : port_word[15:0]} :
		port_word;
	wire [1:0] next_oe = rd_act ? (is32 ? 2'b11 : (is16 ? 2'b01 : 2'b00)) : 2'b00;

	logic [31:0] dout;
	logic [1:0] oe;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dout <= 32'h0000_0000;
			oe <= 2'b00;
		end else begin
			dout <= next_dout;
			oe <= next_oe;
		end
	end

	assign bus.dev_dout = dout;
	assign bus.dev_oe = oe;

	// ****************************************
	// User side status
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			write_done <= 1'b0;
			bus_width <= WIDTH_8;
			endian_select <= 1'b0;
		end else begin
			write_done <= commit;
			bus_width <= is32 ? WIDTH_32 : (is16 ? WIDTH_16 : WIDTH_8);
			endian_select <= endian_now;
		end
	end

	assign user_rdata = user_word;

endmodule : host_port_device

// ==== bench/host_port_assertions.sv ====
// Checker on the pins between the host bus controller and the device port
`timescale 1ns/10ps
module host_port_assertions import host_port_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic lane3_write_or_endian_pin,
	input wire logic lane0_write_n,
	input wire logic width_strap_low,
	input wire logic width_strap_high,
	input wire logic [1:0] host_oe,
	input wire logic [1:0] dev_oe,
	input wire logic write_done,
	input wire bus_width_t bus_width,
	input wire logic endian_select
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ****************************************
	// Read path
	// ****************************************
	property p_rd_gate; dev_oe != 2'h0 |-> $past(!cs_n && !rd_n, 3); endproperty
	a_rd_gate: assert property (p_rd_gate) else $error("data driven without select and read");
	property p_rd_start;
		$rose(!cs_n && !rd_n) && bus_width == WIDTH_32 |-> ##3 dev_oe == 2'h3;
	endproperty
	a_rd_start: assert property (p_rd_start) else $error("read drive late");
	property p_no_clash; (dev_oe & host_oe) == 2'h0; endproperty
	a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
	property p_upper; bus_width == WIDTH_16 |-> !dev_oe[1]; endproperty
	a_upper: assert property (p_upper) else $error("upper half driven in 16-bit");
	property p_no_drive8; bus_width == WIDTH_8 |-> dev_oe == 2'h0; endproperty
	a_no_drive8: assert property (p_no_drive8) else $error("data driven in 8-bit");

	// ****************************************
	// Write path
	// ****************************************
	property p_wr_end; $rose(cs_n) && $past(!lane0_write_n) |-> ##[2:5] write_done; endproperty
	a_wr_end: assert property (p_wr_end) else $error("write not committed");
	property p_done_pulse; write_done |=> !write_done; endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");

	// ****************************************
	// Width and endian decode
	// ****************************************
	property p_width;
		$stable({width_strap_high, width_strap_low}) [*6] |-> bus_width ==
			(width_strap_high ? WIDTH_32 : (width_strap_low ? WIDTH_16 : WIDTH_8));
	endproperty
	a_width: assert property (p_width) else $error("width decode wrong");
	property p_endian;
		(bus_width == WIDTH_16 && $stable(lane3_write_or_endian_pin)) [*4]
			|-> endian_select == lane3_write_or_endian_pin;
	endproperty
	a_endian: assert property (p_endian) else $error("endian select wrong");
	property p_endian_off; (bus_width == WIDTH_32) [*3] |-> !endian_select; endproperty
	a_endian_off: assert property (p_endian_off) else $error("endian set in 32-bit");
endmodule : host_port_assertions

// ==== bench/host_cpu_bus_port_test.sv ====
// Self-checking bench joining the host controller and the device port
`timescale 1ns/10ps
`include "host_port_regs.svh"
module host_cpu_bus_port_test import host_port_pkg::*;;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic hsel = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [8:0] user_addr = 9'h005;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [31:0] user_rdata;
	logic write_done;
	logic endian_select;
	bus_width_t bus_width;
	int fails = 0;
	int checks = 0;

	always #10 ref_clk = ~ref_clk;

	host_port_if bus_if ();
	host_port_host #(.BOOT_WAIT(2)) host_port_host_i (.ref_clk(ref_clk), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .bus(bus_if.host));
	host_port_device host_port_device_i (.ref_clk(ref_clk), .rst(rst), .bus(bus_if.device),
		.user_addr(user_addr), .user_rdata(user_rdata), .write_done(write_done),
		.bus_width(bus_width), .endian_select(endian_select));
	host_port_assertions host_port_assertions_i (.ref_clk(ref_clk), .rst(rst),
		.cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n),
		.lane3_write_or_endian_pin(bus_if.lane3_write_or_endian_pin),
		.lane0_write_n(bus_if.lane0_write_n), .width_strap_low(bus_if.width_strap_low),
		.width_strap_high(bus_if.width_strap_high), .host_oe(bus_if.host_oe),
		.dev_oe(bus_if.dev_oe), .write_done(write_done), .bus_width(bus_width),
		.endian_select(endian_select));

	// ****************************************
	// Shared tasks
	// ****************************************
	task stop_test;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge ref_clk);
		while (hreadyout !== 1'h1) @(posedge ref_clk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge ref_clk);
		while (hreadyout !== 1'h1) @(posedge ref_clk);
		r = hrdata;
	endtask : ahb

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'h1, a, d, r);
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] r);
		ahb(1'h0, a, 32'h0, r);
	endtask : rd

	// One pin access run by the controller; waits for idle, then for done
	task op(input logic w, input logic [3:0] ln, input logic [9:0] a, input logic [31:0] d);
		logic [31:0] r;
		r = 32'h1;
		while (r[`STAT_BUSY] !== 1'h0) rd(`REG_STATUS, r);
		wr(`REG_ADDR, {22'h0, a});
		wr(`REG_WDATA, d);
		wr(`REG_CMD, {24'h0, ln, 2'h0, w, 1'h1});
		r = 32'h0;
		while (r[`STAT_DONE] !== 1'h1) rd(`REG_STATUS, r);
		wr(`REG_STATUS, 32'h2);
		// Device commits a few edges after the strobes rise
		repeat (4) @(posedge ref_clk);
	endtask : op

	function logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] ln);
		merge = o;
		for (int b = 0; b < 4; b++) if (ln[b]) merge[8*b +: 8] = n[8*b +: 8];
	endfunction : merge

	// ****************************************
	// Scenarios
	// ****************************************
	task t_lanes32;
		logic [31:0] r;
		logic [31:0] m;
		logic [31:0] d;
		logic [3:0] lanes [7] = '{4'hF, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC};
		rd(`REG_CONFIG, r);
		chk("config", r, 32'h2);
		chk("width32", {30'h0, bus_width}, {30'h0, WIDTH_32});
		m = 32'h0;
		for (int i = 0; i < 7; i++) begin
			d = 32'h80C0E0F0 ^ {4{i[7:0]}};
			op(1'h1, lanes[i], 10'h005, d);
			m = merge(m, d, lanes[i]);
			chk("word32", user_rdata, m);
			op(1'h0, 4'h0, 10'h005, 32'h0);
			rd(`REG_RDATA, r);
			chk("read32", r, m);
		end
		op(1'h1, 4'hF, 10'h1FF, 32'h5A5AA5A5);
		chk("other_word", user_rdata, m);
		user_addr <= 9'h1FF;
		repeat (2) @(posedge ref_clk);
		chk("top_word", user_rdata, 32'h5A5AA5A5);
	endtask : t_lanes32

	task t_mode16;
		logic [31:0] r;
		logic [31:0] m;
		logic [15:0] d;
		logic [1:0] ln;
		logic e;
		logic a1;
		logic hf;
		user_addr <= 9'h007;
		m = 32'hCAFEF00D;
		op(1'h1, 4'hF, 10'h007, m);
		for (int i = 0; i < 4; i++) begin
			e = i[1];
			a1 = i[0];
			ln = (i == 3) ? 2'h2 : 2'h3;
			d = 16'h1357 + i[15:0];
			hf = a1 ^ e;
			wr(`REG_CONFIG, {29'h0, e, 2'h1});
			repeat (4) @(posedge ref_clk);
			chk("width16", {30'h0, bus_width}, {30'h0, WIDTH_16});
			chk("endian", {31'h0, endian_select}, {31'h0, e});
			op(1'h1, {2'h0, ln}, {a1, 9'h007}, {16'h0, d});
			m = merge(m, {d, d}, hf ? {ln, 2'h0} : {2'h0, ln});
			chk("word16", user_rdata, m);
			op(1'h0, 4'h0, {a1, 9'h007}, 32'h0);
			rd(`REG_RDATA, r);
			chk("read16", r, {16'h0, hf ? m[31:16] : m[15:0]});
		end
	endtask : t_mode16

	// 8-bit straps: the port serves nothing, so the write is lost and the read floats low
	task t_mode8;
		logic [31:0] r;
		user_addr <= 9'h1FF;
		wr(`REG_CONFIG, 32'h0);
		repeat (4) @(posedge ref_clk);
		chk("width8", {30'h0, bus_width}, {30'h0, WIDTH_8});
		op(1'h1, 4'hE, 10'h1FF, 32'h0BADF00D);
		chk("word8", user_rdata, 32'h5A5AA5A5);
		op(1'h0, 4'h0, 10'h1FF, 32'h0);
		rd(`REG_RDATA, r);
		chk("read8", r, 32'h0);
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask : t_mode8

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		t_lanes32;
		t_mode16;
		t_mode8;
		stop_test;
	end

	initial begin
		repeat (60000) @(posedge ref_clk);
		fails++;
		stop_test;
	end
endmodule : host_cpu_bus_port_test
